// ---- core/vocoder_port_pkg.sv ----
`default_nettype none
package vocoder_port_pkg;
  // system clock and serial timing
  localparam int unsigned CLK_SYS_HZ = 40_000_000;
  localparam int unsigned SCLK_HZ = 2_000_000;
  localparam int unsigned SAMPLE_HZ = 8_000;
  localparam int unsigned SCLK_HALF_CYC = CLK_SYS_HZ / (2 * SCLK_HZ);
  localparam int unsigned SAMPLE_CYC = CLK_SYS_HZ / SAMPLE_HZ;
  localparam int unsigned PCM_BITS = 16;
  // probe window after reset release, in cycles
  localparam int unsigned PROBE_CYC = 64;
  // bit positions of mode controls in their host registers
  localparam int unsigned AUTO_DIS_BIT = 7;
  localparam int unsigned CODEC_ENA_BIT = 0;
  // reset values
  localparam logic [15:0] PCM_RESET = 16'h0000;
  typedef enum logic [2:0] {
    PORT_OFF = 3'h1,
    PORT_VOCODER = 3'h2,
    PORT_CODEC = 3'h4
  } port_mode_t;
endpackage
`default_nettype wire

// ---- core/pcm_shifter.sv ----
`default_nettype none
module pcm_shifter
  import vocoder_port_pkg::*;
#(
  parameter int unsigned WIDTH = PCM_BITS,
  parameter int unsigned HALF_CYC = SCLK_HALF_CYC
) (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic start_in,
  input wire logic [WIDTH-1:0] tx_word_in,
  input wire logic sdi_in,
  output logic sclk_out,
  output logic sdo_out,
  output logic cs_n_out,
  output logic [WIDTH-1:0] rx_word_out,
  output logic done_out
);
  localparam int unsigned CW = $clog2(HALF_CYC + 1);
  localparam int unsigned BW = $clog2(WIDTH + 1);
  logic [CW-1:0] div;
  logic [BW-1:0] bits;
  logic [WIDTH-1:0] tx_sh;
  logic [WIDTH-1:0] rx_sh;
  logic busy;
  wire tick = (div == CW'(HALF_CYC - 1));
  wire last = (bits == BW'(WIDTH - 1));
  wire fall = busy && tick && sclk_out;
  wire rise = busy && tick && !sclk_out;
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div <= '0;
      bits <= '0;
      busy <= 1'b0;
      sclk_out <= 1'b0;
      sdo_out <= 1'b0;
      cs_n_out <= 1'b1;
      tx_sh <= '0;
      rx_sh <= '0;
      rx_word_out <= '0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      div <= (busy && !tick) ? div + CW'(1) : '0;
      if (start_in && !busy) begin
        busy <= 1'b1;
        cs_n_out <= 1'b0;
        bits <= '0;
        sdo_out <= tx_word_in[WIDTH-1];
        tx_sh <= {tx_word_in[WIDTH-2:0], 1'b0};
      end
      if (rise) begin
        sclk_out <= 1'b1;
        rx_sh <= {rx_sh[WIDTH-2:0], sdi_in};
      end
      if (fall) begin
        sclk_out <= 1'b0;
        if (last) begin
          busy <= 1'b0;
          cs_n_out <= 1'b1;
          sdo_out <= 1'b0;
          rx_word_out <= rx_sh;
          done_out <= 1'b1;
        end else begin
          bits <= bits + BW'(1);
          sdo_out <= tx_sh[WIDTH-1];
          tx_sh <= {tx_sh[WIDTH-2:0], 1'b0};
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- core/vocoder_port_mode_control.sv ----
// Contract
// - after reset the block probes the aux port for the companion vocoder and latches the result.
// - detected vocoder, auto-disable 0, codec mode 0 gives vocoder mode; the audio routing outputs stay low.
// - codec mode 0 with auto-disable 1 or no vocoder gives payload pass-through to the host.
// - codec mode exchanges signed 16-bit linear samples at 8 ksps each way.
// - in transmit the filtered microphone samples shift out on aux_serial_out.
// - in receive samples shift in on aux_serial_in and are filtered to output path one.
// - no vocoder, auto-disable 0, codec mode 1 enables the port only during a voice call.
// - with no vocoder detected, auto-disable set overrides gating so the port follows codec_port_enable.
// - under override the port is off while codec_port_enable is 0 and on while it is 1.
// - each transfer is 16 serial clock pulses at 2 MHz by default.
`default_nettype none
module vocoder_port_mode_control
  import vocoder_port_pkg::*;
#(
  parameter int unsigned WIDTH = PCM_BITS,
  parameter int unsigned SAMPLE_PERIOD = SAMPLE_CYC
) (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic [7:0] modem_config_in,
  input wire logic [7:0] codec_control_in,
  input wire logic codec_mode_in,
  input wire logic voice_call_in,
  input wire logic tx_active_in,
  input wire logic rx_active_in,
  input wire logic vocoder_present_in,
  input wire logic [WIDTH-1:0] mic_sample_in,
  input wire logic aux_serial_in,
  output logic aux_serial_out,
  output logic aux_sclk_out,
  output logic aux_cs_n_out,
  output logic probe_done_out,
  output logic vocoder_detected_out,
  output logic vocoder_mode_out,
  output logic host_payload_out,
  output logic codec_port_active_out,
  output logic input_path_two_out,
  output logic output_path_one_out,
  output logic [WIDTH-1:0] audio_sample_out,
  output logic audio_valid_out
);
  localparam int unsigned SW = $clog2(SAMPLE_PERIOD + 1);
  localparam int unsigned PW = $clog2(PROBE_CYC + 1);
  localparam int unsigned NPIN = 2;
  localparam int unsigned PIN_SDI = 0;
  localparam int unsigned PIN_PRES = 1;
  wire [NPIN-1:0] pin_raw = {vocoder_present_in, aux_serial_in};
  wire [NPIN-1:0] pin_sync;
  logic [PW-1:0] probe_cnt;
  logic [SW-1:0] sample_cnt;
  logic [WIDTH-1:0] mic_lp;
  logic [WIDTH-1:0] audio_lp;
  logic [WIDTH-1:0] rx_word;
  logic rx_done;
  logic sclk;
  logic sdo;
  logic cs_n;
  port_mode_t mode;
  port_mode_t next_mode;
  // low pass step: sign-extended sum so the average cannot overflow
  function automatic logic [WIDTH-1:0] avg_step(input logic [WIDTH-1:0] prev,
                                                 input logic [WIDTH-1:0] sample);
    logic [WIDTH:0] sum;
    sum = {prev[WIDTH-1], prev} + {sample[WIDTH-1], sample};
    return sum[WIDTH:1];
  endfunction
  // flag for one one-hot state
  function automatic logic in_mode(input port_mode_t cur, input port_mode_t want);
    return cur == want;
  endfunction
  // two-stage synchronisers for pins
  for (genvar i = 0; i < NPIN; i++) begin : g_sync
    logic meta;
    logic sync;
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        meta <= 1'b0;
        sync <= 1'b0;
      end else begin
        meta <= pin_raw[i];
        sync <= meta;
      end
    end
    assign pin_sync[i] = sync;
  end
  wire sdi_sync = pin_sync[PIN_SDI];
  wire pres_sync = pin_sync[PIN_PRES];
  // presence probe after reset release
  wire probing = (probe_cnt != PW'(PROBE_CYC));
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      probe_cnt <= '0;
      vocoder_detected_out <= 1'b0;
      probe_done_out <= 1'b0;
    end else if (probing) begin
      probe_cnt <= probe_cnt + PW'(1);
      if (pres_sync) vocoder_detected_out <= 1'b1;
    end else begin
      probe_done_out <= 1'b1;
    end
  end
  // mode decode
  wire auto_dis = modem_config_in[AUTO_DIS_BIT];
  wire codec_ena = codec_control_in[CODEC_ENA_BIT];
  wire detected = vocoder_detected_out;
  wire call_busy = voice_call_in && (tx_active_in || rx_active_in);
  wire vocoder_sel = detected && !auto_dis && !codec_mode_in;
  wire payload_sel = !codec_mode_in && (auto_dis || !detected);
  wire auto_gate = !detected && !auto_dis && codec_mode_in && call_busy;
  wire override_gate = !detected && auto_dis && codec_ena;
  wire vocoder_on = probe_done_out && vocoder_sel;
  wire payload_on = probe_done_out && payload_sel;
  wire codec_on = probe_done_out && (auto_gate || override_gate);
  // mode choice, inputs count only once the probe is over
  always_comb begin
    next_mode = PORT_OFF;
    case ({vocoder_on, codec_on})
      2'b10: next_mode = PORT_VOCODER;
      2'b01: next_mode = PORT_CODEC;
      default: next_mode = PORT_OFF;
    endcase
  end
  wire next_vocoder = in_mode(next_mode, PORT_VOCODER);
  wire next_codec = in_mode(next_mode, PORT_CODEC);
  wire codec_now = in_mode(mode, PORT_CODEC);
  // mode state
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode <= PORT_OFF;
    end else begin
      mode <= next_mode;
    end
  end
  // mode outputs
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      vocoder_mode_out <= 1'b0;
      host_payload_out <= 1'b0;
    end else begin
      vocoder_mode_out <= next_vocoder;
      host_payload_out <= payload_on;
    end
  end
  // codec port enable and audio routing
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      codec_port_active_out <= 1'b0;
      input_path_two_out <= 1'b0;
      output_path_one_out <= 1'b0;
    end else begin
      codec_port_active_out <= next_codec;
      input_path_two_out <= next_codec;
      output_path_one_out <= next_codec;
    end
  end
  // 8 ksps sample strobe while codec port is on
  wire strobe = codec_now && (sample_cnt == SW'(SAMPLE_PERIOD - 1));
  wire [SW-1:0] next_sample_cnt = (!codec_now || strobe) ? '0 : sample_cnt + SW'(1);
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sample_cnt <= '0;
    end else begin
      sample_cnt <= next_sample_cnt;
    end
  end
  // mic low pass, the fresh value is the word sent
  wire [WIDTH-1:0] next_mic_lp = avg_step(mic_lp, mic_sample_in);
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mic_lp <= PCM_RESET;
    end else if (strobe) begin
      mic_lp <= next_mic_lp;
    end
  end
  // received low pass and audio output
  wire [WIDTH-1:0] next_audio_lp = avg_step(audio_lp, rx_word);
  wire audio_wanted = rx_active_in || auto_dis;
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      audio_lp <= PCM_RESET;
      audio_sample_out <= PCM_RESET;
    end else if (rx_done) begin
      audio_lp <= next_audio_lp;
      audio_sample_out <= next_audio_lp;
    end
  end
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      audio_valid_out <= 1'b0;
    end else begin
      audio_valid_out <= rx_done && audio_wanted;
    end
  end
  // serial engine; a word in flight still finishes if the port drops
  pcm_shifter #(
    .WIDTH(WIDTH),
    .HALF_CYC(SCLK_HALF_CYC)
  ) u_shift (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .start_in(strobe),
    .tx_word_in(next_mic_lp),
    .sdi_in(sdi_sync),
    .sclk_out(sclk),
    .sdo_out(sdo),
    .cs_n_out(cs_n),
    .rx_word_out(rx_word),
    .done_out(rx_done)
  );
  // registered pin outputs, idle while no transfer runs
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      aux_sclk_out <= 1'b0;
      aux_serial_out <= 1'b0;
      aux_cs_n_out <= 1'b1;
    end else begin
      aux_sclk_out <= sclk;
      aux_serial_out <= sdo;
      aux_cs_n_out <= cs_n;
    end
  end
endmodule
`default_nettype wire

// ---- test/vocoder_port_mode_control_asserts.sv ----
`default_nettype none
module vocoder_port_checker (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic [7:0] modem_config_in,
  input wire logic [7:0] codec_control_in,
  input wire logic codec_mode_in,
  input wire logic voice_call_in,
  input wire logic tx_active_in,
  input wire logic rx_active_in,
  input wire logic aux_sclk_out,
  input wire logic aux_cs_n_out,
  input wire logic probe_done_out,
  input wire logic vocoder_detected_out,
  input wire logic vocoder_mode_out,
  input wire logic host_payload_out,
  input wire logic codec_port_active_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  logic [4:0] n_rise;
  logic sclk_q;
  wire logic dis = modem_config_in[7];
  wire logic call = voice_call_in && (tx_active_in || rx_active_in);
  wire logic spi = probe_done_out && !vocoder_detected_out && codec_mode_in;
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) n_rise <= 5'h00;
    else if (aux_cs_n_out) n_rise <= 5'h00;
    else if (aux_sclk_out && !sclk_q) n_rise <= n_rise + 5'h01;
  end
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) sclk_q <= 1'b0;
    else sclk_q <= aux_sclk_out;
  end
  probe_end_a: assert property ($rose(arst_n_in) |-> ##[1:67] probe_done_out)
    else $error("probe never ended");
  auto_vocoder_a: assert property ((probe_done_out && vocoder_detected_out && !dis
    && !codec_mode_in)[*2] |-> vocoder_mode_out) else $error("no vocoder mode");
  host_payload_a: assert property ((probe_done_out && !codec_mode_in
    && (dis || !vocoder_detected_out))[*2] |-> host_payload_out && !vocoder_mode_out)
    else $error("no payload mode");
  gate_on_a: assert property ((spi && !dis && call)[*2] |-> codec_port_active_out)
    else $error("port not gated on");
  gate_off_a: assert property ((spi && !dis && !call)[*2] |-> !codec_port_active_out)
    else $error("port not gated off");
  override_on_a: assert property ((spi && dis && codec_control_in[0])[*2]
    |-> codec_port_active_out) else $error("override on ignored");
  override_off_a: assert property ((probe_done_out && !vocoder_detected_out && dis
    && !codec_control_in[0])[*2] |-> !codec_port_active_out) else $error("override off ignored");
  idle_clock_a: assert property (aux_cs_n_out |-> !aux_sclk_out)
    else $error("clock while deselected");
  pulse_count_a: assert property ($rose(aux_cs_n_out) |-> n_rise == 5'h10)
    else $error("wrong pulse count");
endmodule
bind vocoder_port_mode_control vocoder_port_checker vocoder_port_checker_inst (.clk_sys_in,
  .arst_n_in, .modem_config_in, .codec_control_in, .codec_mode_in, .voice_call_in,
  .tx_active_in, .rx_active_in, .aux_sclk_out, .aux_cs_n_out, .probe_done_out,
  .vocoder_detected_out, .vocoder_mode_out, .host_payload_out, .codec_port_active_out);
`default_nettype wire

// ---- test/pcm_vocoder_model.sv ----
`default_nettype none
module pcm_vocoder_model (
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic sdo_in,
  input wire logic [15:0] word_in,
  output logic sdi_out,
  output logic [15:0] got_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] idx = 4'hF;
  always @(negedge cs_n_in) idx = 4'hF;
  always @(negedge sclk_in) if (!cs_n_in) idx = idx - 4'h1;
  always @(posedge sclk_in) if (!cs_n_in) got_out = {got_out[14:0], sdo_in};
  assign sdi_out = cs_n_in ? ~word_in[0] : word_in[idx];
endmodule
`default_nettype wire

// ---- test/vocoder_port_mode_control_tb_top.sv ----
`default_nettype none
module vocoder_port_mode_control_tb_top import vocoder_port_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys_in = 1'b0, arst_n_in = 1'b0, codec_mode_in = 1'b0, voice_call_in = 1'b0;
  logic tx_active_in = 1'b0, rx_active_in = 1'b0, vocoder_present_in = 1'b0;
  logic [7:0] modem_config_in = 8'h00, codec_control_in = 8'h00;
  logic [15:0] mic_sample_in = 16'hA5C3, audio_sample_out, got;
  logic aux_serial_in, aux_serial_out, aux_sclk_out, aux_cs_n_out, probe_done_out;
  logic vocoder_detected_out, vocoder_mode_out, host_payload_out, codec_port_active_out;
  logic input_path_two_out, output_path_one_out, audio_valid_out;
  int n_mismatch = 0, total_checks = 0;
  always #12.5 clk_sys_in = ~clk_sys_in;
  vocoder_port_mode_control #(.SAMPLE_PERIOD(400)) vocoder_port_mode_control_inst (
    .clk_sys_in, .arst_n_in, .modem_config_in, .codec_control_in, .codec_mode_in,
    .voice_call_in, .tx_active_in, .rx_active_in, .vocoder_present_in, .mic_sample_in,
    .aux_serial_in, .aux_serial_out, .aux_sclk_out, .aux_cs_n_out, .probe_done_out,
    .vocoder_detected_out, .vocoder_mode_out, .host_payload_out, .codec_port_active_out,
    .input_path_two_out, .output_path_one_out, .audio_sample_out, .audio_valid_out);
  pcm_vocoder_model pcm_vocoder_model_inst (.sclk_in(aux_sclk_out), .cs_n_in(aux_cs_n_out),
    .sdo_in(aux_serial_out), .word_in(16'h1234), .sdi_out(aux_serial_in), .got_out(got));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("mismatches %0d checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic restart(input logic pres);
    @(posedge clk_sys_in) arst_n_in <= 1'b0;
    vocoder_present_in <= pres;
    repeat (6) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    repeat (70) @(negedge clk_sys_in);
  endtask
  task automatic set(input logic dis, cm, ena, call, input logic [1:0] trx);
    @(posedge clk_sys_in);
    modem_config_in <= {dis, 7'h00};
    codec_mode_in <= cm;
    codec_control_in <= {7'h00, ena};
    voice_call_in <= call;
    {tx_active_in, rx_active_in} <= trx;
    repeat (3) @(negedge clk_sys_in);
  endtask
  initial begin
    restart(1'b1);
    check({probe_done_out, vocoder_detected_out}, 2'h3);
    set(1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
    check({vocoder_mode_out, host_payload_out}, 2'h2);
    set(1'b1, 1'b0, 1'b0, 1'b0, 2'h0);
    check({vocoder_mode_out, host_payload_out}, 2'h1);
    restart(1'b0);
    check(vocoder_detected_out, 1'b0);
    set(1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
    check(host_payload_out, 1'b1);
    set(1'b0, 1'b1, 1'b0, 1'b0, 2'h3);
    repeat (450) @(negedge clk_sys_in);
    check({codec_port_active_out, aux_cs_n_out, aux_sclk_out}, 3'h2);
    set(1'b0, 1'b1, 1'b0, 1'b1, 2'h1);
    check({codec_port_active_out, input_path_two_out, output_path_one_out}, 3'h7);
    for (int i = 0; i < 1000 && audio_valid_out !== 1'b1; i++) @(negedge clk_sys_in);
    check(audio_valid_out, 1'b1);
    check(audio_sample_out, 16'h091A);
    check(got, 16'hD2E1);
    set(1'b1, 1'b1, 1'b0, 1'b0, 2'h0);
    check(codec_port_active_out, 1'b0);
    set(1'b1, 1'b1, 1'b1, 1'b0, 2'h0);
    check(codec_port_active_out, 1'b1);
    summarize();
  end
  initial begin
    #400000;
    n_mismatch++;
    summarize();
  end
endmodule
`default_nettype wire
